// *** fcrp_pkg.sv ***
// package of constants and types for the flash controller with region protection
package fcrp_pkg;

	// flash geometry
	localparam int unsigned FLASH_AW = 16;               // byte offset width, 36KB main block
	localparam int unsigned ROW_AW = 13;                 // 64-bit row index width
	localparam int unsigned BOUND_W = 6;                 // 1KB bound width
	localparam int unsigned BOUND_LSB = 10;              // 1KB granularity shift
	localparam int unsigned PAGE_LSB = 11;               // 2KB page granularity shift
	localparam int unsigned REGION_N = 4;                // guard regions
	localparam int unsigned CHUNK_ROWS = 2;              // 16B chunk = two 64-bit rows
	localparam int unsigned PF_MAX = 4;                  // most chunks prefetched

	// timing at 40 MHz
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned PROG_US = 40;                // one 32-bit program
	localparam int unsigned PROG_CYCLES = PROG_US * CLK_MHZ;
	localparam int unsigned ERASE_US = 40;               // page, mass and ref-cell erase
	localparam int unsigned ERASE_CYCLES = ERASE_US * CLK_MHZ;

	// wait state selection codes
	localparam logic [1:0] SPEED_SLOW = 2'h0;            // 4 MHz or slower
	localparam logic [1:0] SPEED_MID = 2'h1;             // 8 to 16 MHz
	localparam logic [1:0] SPEED_FAST = 2'h2;            // 32 MHz

	// agent codes in the log
	localparam logic AGENT_HOST = 1'b0;
	localparam logic AGENT_DMA = 1'b1;
	// transfer type in the log
	localparam logic [1:0] XFER_FLASH_RD = 2'h1;

	// commands for the sequencer
	typedef enum logic [2:0]
	{
		CMD_NONE = 3'b000,
		CMD_PROG = 3'b001,
		CMD_PAGE_ERASE = 3'b010,
		CMD_MASS_ERASE = 3'b011,
		CMD_REF_ERASE = 3'b100
	} fcrp_cmd_type;

	// one guard region
	typedef struct packed
	{
		logic enable;
		logic host_rd;
		logic dma_rd;
		logic [BOUND_W-1:0] lower;
		logic [BOUND_W-1:0] upper;
	} fcrp_region_type;

	// violation log
	typedef struct packed
	{
		logic agent;
		logic [FLASH_AW-1:0] offset;
		logic [1:0] xfer;
	} fcrp_log_type;

endpackage

// *** fcrp_array.sv ***
// flash array model with registered 64-bit read data
`timescale 1ns/1ps
module fcrp_array
	import fcrp_pkg::*;
#(
	parameter int unsigned ROWS = 4608
)
(
	// clock, no reset
	input wire logic sys_clk,
	// read
	input wire logic rd_en,
	input wire logic [ROW_AW-1:0] rd_row,
	output logic [63:0] rd_data,
	// write of one 32-bit half
	input wire logic wr_en,
	input wire logic [ROW_AW-1:0] wr_row,
	input wire logic wr_hi,
	input wire logic [31:0] wr_data
);

	logic [63:0] mem [ROWS];   // cell storage

	// registered read port
	always_ff @(posedge sys_clk)
	begin
		if (rd_en)
			rd_data <= mem[rd_row];
	end

	// program overwrites one 32-bit half with the data; erase commands leave the cells unchanged
	always_ff @(posedge sys_clk)
	begin
		if (wr_en && wr_hi)
			mem[wr_row][63:32] <= wr_data;
		else if (wr_en)
			mem[wr_row][31:0] <= wr_data;
	end

endmodule

// *** fcrp_ctrl.sv ***
// flash controller: read ports, wait states, prefetch, sequencer, guard regions
// Function
// RULE1: tight port returns 64-bit read data
// RULE2: AHB accepts 32-bit single and burst reads
// RULE3: optional AHB prefetch of 1-4 16B chunks
// RULE4: page erase of 2KB on command; the code only times it and leaves the cells unchanged
// RULE5: 32-bit program takes 40us, optional interrupt
// RULE6: mass erase on command, optional interrupt; the code only times it and leaves the cells unchanged
// RULE7: reference cell erase on command; the code only times it and leaves the cells unchanged
// RULE8: slow clock: zero wait, back-to-back one wait
// RULE9: mid one wait, fast two, AHB two mid
// RULE10: host and DMA agents from master id
// RULE11: write lockout held until warm reset
// RULE12: four regions, 6-bit 1KB bounds on offset
// RULE13: no region checks for OTP accesses
// RULE14: regions disabled after reset
// RULE15: region has enable, host and DMA flags
// RULE16: locked flags ignore writes until reset
// RULE17: overlap needs every covering region's enable
// RULE18: violating read completes, data replaced
// RULE19: violation event logs agent, offset, type
// RULE20: debug mode breakpoint, else interrupt
// RULE21: scan mode gates flash controls
// RULE22: tight port requests checked too
// RULE23: log holds first violation until cleared
`timescale 1ns/1ps
module fcrp_ctrl
	import fcrp_pkg::*;
#(
	parameter int unsigned ROWS = 4608,
	parameter int unsigned PROG_CNT = PROG_CYCLES,
	parameter int unsigned ERASE_CNT = ERASE_CYCLES
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// tight instruction port
	input wire logic itp_req,
	input wire logic itp_otp,
	input wire logic [FLASH_AW-1:0] itp_addr,
	output logic itp_ready,
	output logic [63:0] itp_rdata,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [FLASH_AW-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [3:0] hmaster,
	input wire logic hotp,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// configuration
	input wire logic [1:0] speed_sel,
	input wire logic pf_enable,
	input wire logic [1:0] pf_chunks,
	input wire logic [3:0] dma_master_id,
	input wire logic [31:0] viol_fill,
	input wire logic debug_mode,
	input wire logic scan_mode,
	// commands
	input wire logic cmd_valid,
	input wire fcrp_cmd_type cmd,
	input wire logic [FLASH_AW-1:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	input wire logic cmd_irq_en,
	input wire logic lockout_set,
	output logic cmd_busy,
	output logic cmd_refused,
	output logic cmd_done_irq,
	output logic write_locked,
	// guard regions
	input wire logic [REGION_N-1:0] region_wr,
	input wire fcrp_region_type region_wdata,
	input wire logic [REGION_N-1:0] region_lock_set,
	output fcrp_region_type [REGION_N-1:0] region_cfg,
	output logic [REGION_N-1:0] region_locked,
	// violation
	input wire logic viol_clear,
	output logic viol_irq,
	output logic viol_break,
	output fcrp_log_type viol_log
);

	typedef enum logic [1:0]
	{
		RD_IDLE = 2'b00,
		RD_WAIT = 2'b01,
		RD_DATA = 2'b10
	} fcrp_rd_type;

	typedef enum logic [1:0]
	{
		SQ_IDLE = 2'b00,
		SQ_RUN = 2'b01,
		SQ_DONE = 2'b10
	} fcrp_sq_type;

	localparam int unsigned CNT_W = 17;               // fits the longest operation

	// agent permission over all covering enabled regions
	function automatic logic allowed(input logic [FLASH_AW-1:0] addr, input logic is_dma,
		input fcrp_region_type [REGION_N-1:0] cfg);
		logic [BOUND_W-1:0] kb;
		logic ok;
		kb = addr[BOUND_LSB +: BOUND_W];
		ok = 1'b1;
		for (int i = 0; i < REGION_N; i++)
		begin
			if (cfg[i].enable && kb >= cfg[i].lower && kb <= cfg[i].upper)
				ok = ok & (is_dma ? cfg[i].dma_rd : cfg[i].host_rd); // [RULE17] [RULE15]
		end
		return ok;
	endfunction

	// base wait states for a read
	function automatic logic [1:0] wait_for(input logic [1:0] speed, input logic is_ahb,
		input logic back2back);
		logic [1:0] w;
		case (speed)
			SPEED_SLOW: w = is_ahb ? 2'h1 : {1'b0, back2back};    // [RULE8]
			SPEED_MID: w = is_ahb ? 2'h2 : 2'h1;                  // [RULE9]
			SPEED_FAST: w = 2'h2;                                 // [RULE9]
			default: w = 2'h2;
		endcase
		return w;
	endfunction

	// read engine state
	fcrp_rd_type rd_state;
	logic [1:0] wait_cnt;                 // remaining wait states
	logic rd_is_ahb;                      // current owner of the array read
	logic rd_viol;                        // current read violates protection
	logic rd_word_hi;                     // ahb word select
	logic rd_agent;                       // dma or host
	logic [FLASH_AW-1:0] rd_addr_q;       // address being read
	logic prev_rd;                        // read finished last cycle
	logic arb_ahb_next;                   // rotating priority token
	logic [63:0] arr_rdata;               // array output
	logic arr_rd_en;
	logic [ROW_AW-1:0] arr_rd_row;

	// prefetch buffer: one row tag plus data, walked forward one row at a time
	logic pf_valid;
	logic [ROW_AW-1:0] pf_row;
	logic [63:0] pf_data;
	logic [3:0] pf_left;                  // rows left to prefetch
	logic pf_active;                      // read in flight is a prefetch

	// ahb address phase capture
	logic ahb_pend;
	logic [FLASH_AW-1:0] ahb_addr;
	logic ahb_otp;
	logic ahb_dma;
	logic ahb_rdy;                        // data phase answered, hrdata standing

	// sequencer
	fcrp_sq_type sq_state;
	logic [CNT_W-1:0] sq_cnt;
	fcrp_cmd_type sq_cmd;
	logic [FLASH_AW-1:0] sq_addr;
	logic [31:0] sq_wdata;
	logic sq_irq_en;
	logic arr_wr_en;

	// misc combinational
	logic ahb_take;
	logic ahb_hit_pf;
	logic grant_ahb;
	logic start_rd;
	logic next_viol;
	logic rd_fire;

	// ahb request taken in the address phase; only reads are served
	assign ahb_take = hsel && hready && htrans[1] && !hwrite;  // [RULE2]
	// a buffered row is served only to an agent that may read it, else the array read flags it
	assign ahb_hit_pf = ahb_pend && pf_valid && pf_row == ahb_addr[FLASH_AW-1:3]
		&& (ahb_otp || allowed(ahb_addr, ahb_dma, region_cfg));   // [RULE17] [RULE18]
	// rotating priority between the two ports; an answered request reads nothing more
	assign grant_ahb = ahb_pend && !ahb_hit_pf && !ahb_rdy && (!itp_req || arb_ahb_next);
	assign start_rd = rd_state == RD_IDLE && !scan_mode && !cmd_busy
		&& (itp_req || (ahb_pend && !ahb_hit_pf && !ahb_rdy));
	assign rd_fire = rd_state == RD_WAIT && wait_cnt == 2'h0;

	// array read gated by scan mode
	assign arr_rd_en = rd_fire && !scan_mode;               // [RULE21]
	assign arr_rd_row = rd_addr_q[FLASH_AW-1:3];
	assign arr_wr_en = sq_state == SQ_RUN && sq_cnt == '0 && sq_cmd == CMD_PROG
		&& !scan_mode;                                      // [RULE21]

	fcrp_array #(
		.ROWS(ROWS)
	) u_array (
		.sys_clk(sys_clk),
		.rd_en(arr_rd_en),
		.rd_row(arr_rd_row),
		.rd_data(arr_rdata),
		.wr_en(arr_wr_en),
		.wr_row(sq_addr[FLASH_AW-1:3]),
		.wr_hi(sq_addr[2]),
		.wr_data(sq_wdata)
	);

	// ahb address phase capture
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			ahb_pend <= 1'b0;
			ahb_addr <= '0;
			ahb_otp <= 1'b0;
			ahb_dma <= 1'b0;
		end
		else if (ahb_take)
		begin
			ahb_pend <= 1'b1;
			ahb_addr <= haddr;
			ahb_otp <= hotp;
			ahb_dma <= hmaster == dma_master_id;            // [RULE10]
		end
		else if (hreadyout)
			ahb_pend <= 1'b0;
	end

	// read engine: arbitration, wait states, completion
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rd_state <= RD_IDLE;
			wait_cnt <= 2'h0;
			rd_is_ahb <= 1'b0;
			rd_viol <= 1'b0;
			rd_agent <= AGENT_HOST;
			rd_addr_q <= '0;
			prev_rd <= 1'b0;
			arb_ahb_next <= 1'b0;
			pf_active <= 1'b0;
		end
		else
		begin
			prev_rd <= rd_state == RD_DATA;
			case (rd_state)
				RD_IDLE:
				begin
					if (start_rd)
					begin
						rd_state <= RD_WAIT;
						rd_is_ahb <= grant_ahb;
						arb_ahb_next <= !grant_ahb;
						pf_active <= 1'b0;
						rd_addr_q <= grant_ahb ? ahb_addr : itp_addr;
						rd_agent <= grant_ahb ? ahb_dma : AGENT_HOST;
						// otp reads skip the region check
						rd_viol <= grant_ahb
							? !ahb_otp && !allowed(ahb_addr, ahb_dma, region_cfg) // [RULE13]
							: !itp_otp && !allowed(itp_addr, 1'b0, region_cfg);   // [RULE22]
						wait_cnt <= wait_for(speed_sel, grant_ahb, prev_rd);  // [RULE8]
					end
					else if (pf_enable && pf_left != 4'h0 && !scan_mode && !cmd_busy
						&& !itp_req && !ahb_pend)
					begin
						// idle slot used for the next prefetch row
						rd_state <= RD_WAIT;
						rd_is_ahb <= 1'b1;
						pf_active <= 1'b1;
						rd_viol <= 1'b0;
						rd_addr_q <= {pf_row + ROW_AW'(1), 3'h0};            // [RULE3]
						wait_cnt <= wait_for(speed_sel, 1'b1, 1'b0);
					end
				end
				RD_WAIT:
				begin
					if (wait_cnt != 2'h0)
						wait_cnt <= wait_cnt - 2'h1;
					else
						rd_state <= RD_DATA;
				end
				RD_DATA:
					rd_state <= RD_IDLE;
				default:
					rd_state <= RD_IDLE;
			endcase
		end
	end

	// prefetch row buffer and remaining count
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			pf_valid <= 1'b0;
			pf_row <= '0;
			pf_data <= '0;
			pf_left <= 4'h0;
		end
		else if (rd_state == RD_DATA && rd_is_ahb && !rd_viol)
		begin
			pf_valid <= 1'b1;
			pf_row <= rd_addr_q[FLASH_AW-1:3];
			pf_data <= arr_rdata;
			// a demand read restarts the window: chunks times rows per chunk
			if (!pf_active)
				pf_left <= pf_enable
					? 4'((32'(pf_chunks) + 32'd1) * CHUNK_ROWS) : 4'h0;  // [RULE3]
			else if (pf_left != 4'h0)
				pf_left <= pf_left - 4'h1;
		end
		else if (cmd_busy || !pf_enable)
		begin
			// flash content may change; drop the buffer
			pf_valid <= 1'b0;
			pf_left <= 4'h0;
		end
	end

	// ahb data phase answer: ready rises once hrdata holds the word, the bus samples both
	assign hreadyout = !ahb_pend || ahb_rdy;                    // [RULE2]
	assign hresp = 1'b0;

	// answer flag, one cycle after a buffer hit or the array read of a demand request
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			ahb_rdy <= 1'b0;
		else
			ahb_rdy <= !ahb_rdy && (ahb_hit_pf
				|| (rd_state == RD_DATA && rd_is_ahb && !pf_active));
	end

	// ahb read data from flops; violation returns the fill value
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			hrdata <= '0;
		else if (ahb_pend && !ahb_hit_pf && rd_state == RD_WAIT && rd_fire)
			hrdata <= '0;
		else if (ahb_hit_pf)
			hrdata <= pf_data[32*ahb_addr[2] +: 32];
		else if (rd_state == RD_DATA && rd_is_ahb && !pf_active)
			hrdata <= rd_viol ? viol_fill : arr_rdata[32*rd_addr_q[2] +: 32];  // [RULE18]
	end

	// tight port: 64-bit row, same replacement on violation
	assign itp_ready = rd_state == RD_DATA && !rd_is_ahb;
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			itp_rdata <= '0;
		else if (rd_state == RD_DATA && !rd_is_ahb)
			itp_rdata <= rd_viol ? {viol_fill, viol_fill} : arr_rdata;   // [RULE1] [RULE18]
	end

	// guard regions: cleared by warm reset, locked flags frozen
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			region_cfg <= '0;                                   // [RULE14]
			region_locked <= '0;
		end
		else
		begin
			for (int i = 0; i < REGION_N; i++)
			begin
				if (region_wr[i] && !region_locked[i])
					region_cfg[i] <= region_wdata;              // [RULE12] [RULE16]
				if (region_lock_set[i])
					region_locked[i] <= 1'b1;                   // [RULE16]
			end
		end
	end

	// violation event and first-violation log; a new event beats a clear
	assign next_viol = rd_state == RD_DATA && rd_viol;
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			viol_irq <= 1'b0;
			viol_break <= 1'b0;
			viol_log <= '0;
		end
		else if (next_viol)
		begin
			// a pending event of the other mode stays until its clear
			viol_irq <= !debug_mode || (viol_irq && !viol_clear);      // [RULE20] [RULE23]
			viol_break <= debug_mode || (viol_break && !viol_clear);   // [RULE20] [RULE23]
			// first violation kept while the event is pending
			if (!(viol_irq || viol_break) || viol_clear)
				viol_log <= '{rd_agent, rd_addr_q, XFER_FLASH_RD}; // [RULE19] [RULE23]
		end
		else if (viol_clear)
		begin
			viol_irq <= 1'b0;                                   // [RULE23]
			viol_break <= 1'b0;
		end
	end

	// write and erase lockout until warm reset
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			write_locked <= 1'b0;
		else if (lockout_set)
			write_locked <= 1'b1;                               // [RULE11]
	end

	// sequencer for program and erase; mass erase is guarded only by lockout and scan mode, not by the regions
	assign cmd_busy = sq_state != SQ_IDLE;
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			sq_state <= SQ_IDLE;
			sq_cnt <= '0;
			sq_cmd <= CMD_NONE;
			sq_addr <= '0;
			sq_wdata <= '0;
			sq_irq_en <= 1'b0;
			cmd_refused <= 1'b0;
			cmd_done_irq <= 1'b0;
		end
		else
		begin
			cmd_refused <= 1'b0;
			cmd_done_irq <= 1'b0;
			case (sq_state)
				SQ_IDLE:
				begin
					if (cmd_valid && cmd != CMD_NONE)
					begin
						if (write_locked || scan_mode)
							cmd_refused <= 1'b1;                // [RULE11] [RULE21]
						else
						begin
							sq_state <= SQ_RUN;
							sq_cmd <= cmd;
							sq_addr <= cmd_addr;
							sq_wdata <= cmd_wdata;
							sq_irq_en <= cmd_irq_en;
							// program 40us; erases share one timing constant
							sq_cnt <= cmd == CMD_PROG ? CNT_W'(PROG_CNT - 1)   // [RULE5]
								: CNT_W'(ERASE_CNT - 1);           // [RULE4] [RULE6] [RULE7]
						end
					end
				end
				SQ_RUN:
				begin
					if (sq_cnt != '0)
						sq_cnt <= sq_cnt - CNT_W'(1);
					else
						sq_state <= SQ_DONE;
				end
				SQ_DONE:
				begin
					sq_state <= SQ_IDLE;
					cmd_done_irq <= sq_irq_en;                  // [RULE5] [RULE6]
				end
				default:
					sq_state <= SQ_IDLE;
			endcase
		end
	end

endmodule

// *** fcrp_ctrl_assertions.sv ***
// concurrent checks on the flash controller ports
`timescale 1ns/1ps
module fcrp_ctrl_assertions
	import fcrp_pkg::*;
#(
	parameter int unsigned PROG_CNT = PROG_CYCLES,
	parameter int unsigned ERASE_CNT = ERASE_CYCLES
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// commands
	input wire logic scan_mode,
	input wire logic cmd_valid,
	input wire logic cmd_busy,
	input wire logic cmd_refused,
	input wire logic cmd_done_irq,
	input wire logic write_locked,
	// read ports
	input wire logic itp_ready,
	input wire logic hresp,
	// guard regions and violations
	input wire fcrp_region_type [REGION_N-1:0] region_cfg,
	input wire logic [REGION_N-1:0] region_locked,
	input wire logic viol_clear,
	input wire logic viol_irq,
	input wire logic viol_break,
	input wire fcrp_log_type viol_log
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// longest legal busy run, one cycle of slack for the done edge
	localparam int unsigned BUSY_MAX = ((PROG_CNT > ERASE_CNT) ? PROG_CNT : ERASE_CNT) + 2;
	int unsigned busy_len; // cycles of the current busy run
	// busy run counter; a stuck sequencer shows up here
	always_ff @(posedge sys_clk)
	begin
		if (!resetn || !cmd_busy)
			busy_len <= 0;
		else
			busy_len <= busy_len + 1;
	end
	chk_busy_bounded: assert property (busy_len <= BUSY_MAX)
		else $error("sequencer busy too long");
	chk_done_busy: assert property (cmd_done_irq |-> $past(cmd_busy))
		else $error("done without a busy run");
	chk_refuse_locked: assert property (cmd_valid && !cmd_busy && write_locked |=> cmd_refused)
		else $error("command taken while locked out");
	chk_lock_held: assert property (write_locked |=> write_locked)
		else $error("lockout dropped without reset");
	chk_scan_refuse: assert property (cmd_valid && !cmd_busy && scan_mode |=> cmd_refused)
		else $error("command taken in scan");
	chk_region_frozen: assert property (region_locked[0] |=> $stable(region_cfg[0]))
		else $error("locked region changed");
	chk_itp_single: assert property (itp_ready |=> !itp_ready)
		else $error("tight ready longer than a cycle");
	chk_viol_sticky: assert property (viol_irq && !viol_clear |=> viol_irq)
		else $error("violation event lost");
	chk_log_first: assert property ((viol_irq || viol_break) && $past(viol_irq || viol_break)
		&& !$past(viol_clear) |-> $stable(viol_log))
		else $error("log overwritten while pending");
	chk_no_error: assert property (!hresp)
		else $error("error response on ahb");
endmodule

bind fcrp_ctrl fcrp_ctrl_assertions #(.PROG_CNT(PROG_CNT), .ERASE_CNT(ERASE_CNT)) u_chk (
	.sys_clk(sys_clk), .resetn(resetn), .scan_mode(scan_mode), .cmd_valid(cmd_valid),
	.cmd_busy(cmd_busy), .cmd_refused(cmd_refused), .cmd_done_irq(cmd_done_irq),
	.write_locked(write_locked), .itp_ready(itp_ready), .hresp(hresp),
	.region_cfg(region_cfg), .region_locked(region_locked), .viol_clear(viol_clear),
	.viol_irq(viol_irq), .viol_break(viol_break), .viol_log(viol_log));

// *** fcrp_ahb_master.sv ***
// ahb-lite master model standing in for the core and the dma
`timescale 1ns/1ps
module fcrp_ahb_master
	import fcrp_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// slave answer
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	// request
	output logic hsel,
	output logic [FLASH_AW-1:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic hready,
	output logic [3:0] hmaster,
	output logic hotp
);
	// only slave on the bus, so its ready is the bus ready
	assign hready = hreadyout;
	// idle bus at time zero
	initial
	begin
		hsel = 1'b0;
		haddr = 16'hffff;
		htrans = 2'h0;
		hwrite = 1'b0;
		hmaster = 4'h0;
		hotp = 1'b0;
	end
	// one single read; ok drops when the slave never answers
	task automatic read(input logic [15:0] a, input logic [3:0] m, input logic o,
		output logic [31:0] d, output logic ok);
		int n;
		n = 0;
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2; // nonseq single
		hmaster <= m;
		hotp <= o;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (hready !== 1'b1 && n < 50);
		// released address shows its inverse so a stale value never matches
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~a;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 100);
		// data taken at the edge that samples ready high
		d = hrdata;
		ok = (n < 100);
	endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the flash controller
`timescale 1ns/1ps
module testbench
	import fcrp_pkg::*;
();
	// stimulus, all valued at time zero
	logic sys_clk, resetn = 1'b0, itp_req = 1'b0, itp_otp = 1'b0, pf_enable = 1'b0;
	logic debug_mode = 1'b0, scan_mode = 1'b0, cmd_valid = 1'b0, cmd_irq_en = 1'b1;
	logic lockout_set = 1'b0, viol_clear = 1'b0;
	logic [15:0] itp_addr = 16'h0000, cmd_addr = 16'h0000;
	logic [1:0] speed_sel = SPEED_SLOW, pf_chunks = 2'h3;
	logic [3:0] dma_master_id = 4'h3, region_wr = 4'h0, region_lock_set = 4'h0;
	logic [31:0] viol_fill = 32'hdead_beef, cmd_wdata = 32'h0000_0000;
	fcrp_cmd_type cmd = CMD_NONE;
	fcrp_region_type region_wdata = '0;
	// design answers and bus wires
	logic itp_ready, hreadyout, hresp, cmd_busy, cmd_refused, cmd_done_irq, write_locked;
	logic viol_irq, viol_break, hsel, hwrite, hready, hotp;
	logic [63:0] itp_rdata;
	logic [31:0] hrdata;
	logic [15:0] haddr;
	logic [1:0] htrans;
	logic [3:0] hmaster, region_locked;
	fcrp_region_type [REGION_N-1:0] region_cfg;
	fcrp_log_type viol_log;
	int num_errors = 0, compares = 0, lat[3];
	// short counts keep the run brief
	fcrp_ctrl #(.PROG_CNT(8), .ERASE_CNT(8)) DUT (.sys_clk, .resetn, .itp_req, .itp_otp,
		.itp_addr, .itp_ready, .itp_rdata, .hsel, .haddr, .htrans, .hwrite, .hready,
		.hmaster, .hotp, .hreadyout, .hresp, .hrdata, .speed_sel, .pf_enable, .pf_chunks,
		.dma_master_id, .viol_fill, .debug_mode, .scan_mode, .cmd_valid, .cmd, .cmd_addr,
		.cmd_wdata, .cmd_irq_en, .lockout_set, .cmd_busy, .cmd_refused, .cmd_done_irq,
		.write_locked, .region_wr, .region_wdata, .region_lock_set, .region_cfg,
		.region_locked, .viol_clear, .viol_irq, .viol_break, .viol_log);
	fcrp_ahb_master u_ahb (.sys_clk, .hreadyout, .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hready, .hmaster, .hotp);
	// 40 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// value compare, unknowns never match
	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// a wait that ran out ends the run
	task automatic bail(input logic ok);
		if (!ok)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			conclude();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// tight port read held until ready, data one cycle later
	task automatic itp_rd(input logic [15:0] a, input logic o, input logic [63:0] exp,
		output int n);
		n = 0;
		@(posedge sys_clk);
		itp_req <= 1'b1;
		itp_addr <= a;
		itp_otp <= o;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (itp_ready !== 1'b1 && n < 50);
		bail(n < 50);
		itp_req <= 1'b0;
		@(posedge sys_clk);
		if (!o)
			check(itp_rdata, exp, "tight data");
	endtask
	// ahb single read through the master model
	task automatic ahb_rd(input logic [15:0] a, input logic [3:0] m, input logic [31:0] exp);
		logic [31:0] w;
		logic ok;
		u_ahb.read(a, m, 1'b0, w, ok);
		bail(ok);
		check(64'(w), 64'(exp), "ahb data");
	endtask
	// command pulse, then refusal or completion
	task automatic run_cmd(input fcrp_cmd_type c, input logic [15:0] a, input logic [31:0] d,
		input logic refuse);
		int n;
		n = 0;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		@(posedge sys_clk);
		check(64'(cmd_refused), 64'(refuse), "refusal");
		// the done pulse stands at the edge that first sees busy low
		while (cmd_busy !== 1'b0 && n < 100)
		begin
			@(posedge sys_clk);
			n++;
		end
		bail(n < 100);
		check(64'(cmd_done_irq), 64'(cmd_irq_en && !refuse), "done pulse");
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		tick(3);
		resetn <= 1'b1;
		tick(1);
		check(64'(region_cfg), 64'h0, "regions off");
		check({region_locked, write_locked, viol_irq, hreadyout, cmd_busy}, 8'h02, "idle");
		$display("test reset done");
		run_cmd(CMD_PROG, 16'h0010, 32'h1234_5678, 1'b0);
		run_cmd(CMD_PROG, 16'h0014, 32'h9abc_def0, 1'b0);
		for (int s = 0; s < 3; s++)
		begin
			speed_sel <= 2'(s);
			itp_rd(16'h0010, 1'b0, 64'h9abc_def0_1234_5678, lat[s]);
		end
		check(64'(lat[0]), 64'h3, "slow wait");
		check(64'(lat[1] - lat[0]), 64'h1, "mid wait");
		check(64'(lat[2] - lat[0]), 64'h2, "fast wait");
		$display("test tight reads done");
		for (int p = 0; p < 4; p++)
		begin
			pf_enable <= p[1];
			ahb_rd(16'h0010 + 16'(p[0] * 4), 4'h0, p[0] ? 32'h9abc_def0 : 32'h1234_5678);
		end
		$display("test ahb reads done");
		set_region(0, fcrp_region_type'{1'b1, 1'b0, 1'b1, 6'h00, 6'h00});
		check(64'(region_cfg[0]), 64'h5000, "region write");
		itp_rd(16'h0010, 1'b0, {2{32'hdead_beef}}, lat[0]);
		tick(2);
		check(64'(viol_irq), 64'h1, "event");
		check(64'(viol_log), 64'({AGENT_HOST, 16'h0010, XFER_FLASH_RD}), "log");
		check(64'(viol_break), 64'h0, "no break");
		clear_viol();
		itp_rd(16'h0010, 1'b1, 64'h0, lat[0]);
		ahb_rd(16'h0014, 4'h3, 32'h9abc_def0);
		tick(2);
		check(64'(viol_irq), 64'h0, "otp and dma pass");
		set_region(1, fcrp_region_type'{1'b1, 1'b1, 1'b0, 6'h00, 6'h01});
		debug_mode <= 1'b1;
		ahb_rd(16'h0010, 4'h3, 32'hdead_beef);
		itp_rd(16'h0010, 1'b0, {2{32'hdead_beef}}, lat[0]);
		tick(2);
		check(64'(viol_break), 64'h1, "break");
		check(64'(viol_log), 64'({AGENT_DMA, 16'h0010, XFER_FLASH_RD}), "first log");
		debug_mode <= 1'b0;
		clear_viol();
		$display("test regions done");
		region_lock_set <= 4'h1;
		tick(1);
		region_lock_set <= 4'h0;
		set_region(0, fcrp_region_type'(15'h0000));
		check(64'(region_cfg[0]), 64'h5000, "locked region");
		scan_mode <= 1'b1;
		run_cmd(CMD_PROG, 16'h0018, 32'h0000_0001, 1'b1);
		scan_mode <= 1'b0;
		cmd_irq_en <= 1'b0;
		run_cmd(CMD_PAGE_ERASE, 16'h0800, 32'h0000_0000, 1'b0);
		cmd_irq_en <= 1'b1;
		run_cmd(CMD_MASS_ERASE, 16'h0000, 32'h0000_0000, 1'b0);
		lockout_set <= 1'b1;
		tick(1);
		lockout_set <= 1'b0;
		run_cmd(CMD_PAGE_ERASE, 16'h0800, 32'h0000_0000, 1'b1);
		resetn <= 1'b0;
		tick(3);
		resetn <= 1'b1;
		tick(1);
		check(64'({region_cfg, write_locked}), 64'h0, "warm reset");
		run_cmd(CMD_REF_ERASE, 16'h0000, 32'h0000_0000, 1'b0);
		$display("test commands done");
		conclude();
	end
	// one region write pulse, settled a cycle later
	task automatic set_region(input int i, input fcrp_region_type r);
		@(posedge sys_clk);
		region_wr <= 4'(1 << i);
		region_wdata <= r;
		@(posedge sys_clk);
		region_wr <= 4'h0;
		tick(1);
	endtask
	// clear pulse, event gone after it lands
	task automatic clear_viol();
		viol_clear <= 1'b1;
		tick(1);
		viol_clear <= 1'b0;
		tick(1);
		check(64'({viol_irq, viol_break}), 64'h0, "cleared");
	endtask
endmodule
